// ==== hdl/rsrb_builder.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Header byte 9 reports power-loss persistence.
// - One value: cleared at every power-on.
// - Other value: retained across power loss.
// - Base entries 24 bytes each from byte 24.
// - Extended header bytes 0-23, 24-63 reserved.
// - Extended entries 64 bytes each from byte 64.
// - Entry bytes 0-1 hold controller identifier.
// - Unassociated dynamic controller reports all-ones identifier.
// - Byte 2 bit 0 flags reservation holder.
// - Base entry bytes 8-15 hold host identifier.
// - Base entry bytes 16-23 hold reservation key.
// - Extended entry identifier same as base.
// - Extended entry key sits in bytes 8-15.
// - Extended 128-bit host identifier, bytes 16-31.
// - Select bit one means extended layout.
// - Header bytes 5-6 count appended entries.
// - Send only requested dwords, never pad.
module rsrb_builder (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Request
	input wire logic start_i,
	input wire logic extended_layout_select_i,
	input wire logic [31:0] transfer_dword_count_i,
	input wire logic power_loss_persist_state_i,
	input wire logic [15:0] registered_controller_count_i,
	// Entry lookup, answered in the same cycle as entry_idx_o
	output logic [15:0] entry_idx_o,
	input wire logic [15:0] controller_identifier_i,
	input wire logic dynamic_unassoc_i,
	input wire logic controller_reservation_flag_i,
	input wire logic [127:0] host_identifier_i,
	input wire logic [63:0] reservation_key_i,
	// Report word stream
	output logic dw_valid_o,
	output logic [31:0] dw_data_o,
	output logic dw_last_o,
	input wire logic dw_ready_i,
	// Status
	output logic busy_o,
	output logic done_o
);
	rsrb_pkg::rsrb_state_t state_q;
	logic ext_q;
	logic persist_q;
	logic [15:0] count_q;
	logic [32:0] rem_q;
	logic in_hdr_q;
	logic [3:0] wq;
	logic [15:0] entry_q;
	logic valid_q;
	logic last_q;
	logic [31:0] data_q;
	logic done_q;
	logic busy_q;
	logic [32:0] req_w;
	logic [32:0] total_w;
	logic [4:0] hdr_w;
	logic [4:0] per_w;
	logic [4:0] words_w;
	logic [15:0] id_w;
	logic [31:0] word_w;
	logic advance_w;

	// ------------------------------------------------------------------
	// Sizing of the report
	// ------------------------------------------------------------------
	always_comb
	begin
		hdr_w = extended_layout_select_i ? rsrb_pkg::EXT_HDR_WORDS
			: rsrb_pkg::BASE_HDR_WORDS;
		per_w = extended_layout_select_i ? rsrb_pkg::EXT_ENT_WORDS
			: rsrb_pkg::BASE_ENT_WORDS;
		// The count is zero based, so one more word than written.
		req_w = {1'b0, transfer_dword_count_i} + 33'h0_0000_0001;
		total_w = 33'(hdr_w) + 33'(registered_controller_count_i)
			* 33'(per_w);
	end

	// ------------------------------------------------------------------
	// Word assembly
	// ------------------------------------------------------------------
	always_comb
	begin
		id_w = dynamic_unassoc_i ? rsrb_pkg::UNASSOC_ID
			: controller_identifier_i;
		word_w = rsrb_pkg::WORD_ZERO;
		words_w = in_hdr_q ? (ext_q ? rsrb_pkg::EXT_HDR_WORDS
			: rsrb_pkg::BASE_HDR_WORDS) : (ext_q
			? rsrb_pkg::EXT_ENT_WORDS : rsrb_pkg::BASE_ENT_WORDS);
		if (in_hdr_q)
		begin
			// Words 6 to 15 of the extended header stay zero.
			if (wq == rsrb_pkg::HDR_W_COUNT)
				word_w = {8'h00, count_q, 8'h00};
			else if (wq == rsrb_pkg::HDR_W_PERSIST)
				word_w = {16'h0000, 7'h00, persist_q, 8'h00};
		end
		else if (wq == rsrb_pkg::ENT_W_ID)
			word_w = {8'h00, 7'h00, controller_reservation_flag_i, id_w};
		else if (!ext_q)
		begin
			unique case (wq)
				rsrb_pkg::BASE_W_HOST: word_w = host_identifier_i[31:0];
				4'h3: word_w = host_identifier_i[63:32];
				rsrb_pkg::BASE_W_KEY: word_w = reservation_key_i[31:0];
				4'h5: word_w = reservation_key_i[63:32];
				default: word_w = rsrb_pkg::WORD_ZERO;
			endcase
		end
		else
		begin
			unique case (wq)
				rsrb_pkg::EXT_W_KEY: word_w = reservation_key_i[31:0];
				4'h3: word_w = reservation_key_i[63:32];
				rsrb_pkg::EXT_W_HOST: word_w = host_identifier_i[31:0];
				4'h5: word_w = host_identifier_i[63:32];
				4'h6: word_w = host_identifier_i[95:64];
				4'h7: word_w = host_identifier_i[127:96];
				default: word_w = rsrb_pkg::WORD_ZERO;
			endcase
		end
		// While words remain, a word is loaded whenever the output register is empty or draining.
		advance_w = (state_q == rsrb_pkg::RSRB_RUN) && (rem_q != 33'h0)
			&& (!valid_q || dw_ready_i);
	end

	// ------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			state_q <= rsrb_pkg::RSRB_IDLE;
			ext_q <= 1'b0;
			persist_q <= rsrb_pkg::PERSIST_CLEARED;
			count_q <= 16'h0000;
			rem_q <= 33'h0;
			in_hdr_q <= 1'b1;
			wq <= 4'h0;
			entry_q <= 16'h0000;
			valid_q <= 1'b0;
			last_q <= 1'b0;
			busy_q <= 1'b0;
			data_q <= rsrb_pkg::WORD_ZERO;
			done_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				rsrb_pkg::RSRB_IDLE:
				begin
					done_q <= 1'b0;
					if (start_i)
					begin
						ext_q <= extended_layout_select_i;
						persist_q <= power_loss_persist_state_i;
						count_q <= registered_controller_count_i;
						// The length is fixed here, so later input changes are harmless.
						rem_q <= (req_w < total_w) ? req_w : total_w;
						in_hdr_q <= 1'b1;
						wq <= 4'h0;
						entry_q <= 16'h0000;
						busy_q <= 1'b1;
						state_q <= rsrb_pkg::RSRB_RUN;
					end
				end
				rsrb_pkg::RSRB_RUN:
				begin
					if (advance_w)
					begin
						data_q <= word_w;
						valid_q <= 1'b1;
						last_q <= (rem_q == 33'h1);
						rem_q <= rem_q - 33'h1;
						// Boundaries are counted in words of the current layout.
						if ({1'b0, wq} == words_w - 5'h01)
						begin
							wq <= 4'h0;
							if (in_hdr_q)
								in_hdr_q <= 1'b0;
							else
								entry_q <= entry_q + 16'h0001;
						end
						else
							wq <= wq + 4'h1;
					end
					else if (rem_q == 33'h0 && dw_ready_i)
					begin
						valid_q <= 1'b0;
						last_q <= 1'b0;
						// The last word is taken in this cycle, so valid is cleared here.
						done_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= rsrb_pkg::RSRB_IDLE;
					end
				end
			endcase
		end
	end

	assign entry_idx_o = entry_q;
	assign dw_valid_o = valid_q;
	assign dw_data_o = data_q;
	assign dw_last_o = last_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
endmodule // rsrb_builder

// ==== hdl/rsrb_pkg.sv ====
package rsrb_pkg;
	// ------------------------------------------------------------------
	// Report geometry, in 32-bit words
	// ------------------------------------------------------------------
	localparam logic [4:0] BASE_HDR_WORDS = 5'h06;
	localparam logic [4:0] BASE_ENT_WORDS = 5'h06;
	localparam logic [4:0] EXT_HDR_WORDS = 5'h10;
	localparam logic [4:0] EXT_ENT_WORDS = 5'h10;
	// ------------------------------------------------------------------
	// Field positions, as word index within header or entry
	// ------------------------------------------------------------------
	localparam logic [3:0] HDR_W_COUNT = 4'h1;
	localparam logic [3:0] HDR_W_PERSIST = 4'h2;
	localparam logic [3:0] ENT_W_ID = 4'h0;
	localparam logic [3:0] BASE_W_HOST = 4'h2;
	localparam logic [3:0] BASE_W_KEY = 4'h4;
	localparam logic [3:0] EXT_W_KEY = 4'h2;
	localparam logic [3:0] EXT_W_HOST = 4'h4;
	localparam logic [15:0] UNASSOC_ID = 16'hFFFF;
	// ------------------------------------------------------------------
	// Persistence encoding and reset values
	// ------------------------------------------------------------------
	localparam logic PERSIST_CLEARED = 1'b0;
	localparam logic PERSIST_KEPT = 1'b1;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef enum logic [0:0] {
		RSRB_IDLE = 1'b0,
		RSRB_RUN = 1'b1
	} rsrb_state_t;
endpackage

// ==== verif/rsrb_assertions.sv ====
`timescale 1ns/1ps
module rsrb_checker (
	// Clock, reset and request
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	// Word stream and status
	input wire logic dw_valid_o,
	input wire logic [31:0] dw_data_o,
	input wire logic dw_last_o,
	input wire logic dw_ready_i,
	input wire logic busy_o,
	input wire logic done_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic take, fin;
	assign take = !busy_o && start_i;
	assign fin = dw_valid_o && dw_ready_i && dw_last_o;
	a_first_word: assert property (take |=> busy_o ##1
		(dw_valid_o && dw_data_o == 32'h0)) else $error("first word");
	a_hold_word: assert property (dw_valid_o && !dw_ready_i |=>
		dw_valid_o && $stable(dw_data_o) && $stable(dw_last_o))
		else $error("word not held");
	a_done_last: assert property (fin |=> done_o && !busy_o)
		else $error("no done");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done long");
	a_done_cause: assert property (done_o |-> $past(fin))
		else $error("stray done");
	a_valid_busy: assert property (dw_valid_o |-> busy_o)
		else $error("valid idle");
	a_last_valid: assert property (dw_last_o |-> dw_valid_o)
		else $error("last alone");
	a_busy_holds: assert property (busy_o && !fin |=> busy_o)
		else $error("busy dropped");
	c_take: cover property (take ##1 busy_o);
	c_stall: cover property (dw_valid_o && !dw_ready_i);
	c_fin: cover property (fin ##1 done_o);
endmodule // rsrb_checker
bind rsrb_builder rsrb_checker i_chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.start_i(start_i), .dw_valid_o(dw_valid_o), .dw_data_o(dw_data_o),
	.dw_last_o(dw_last_o), .dw_ready_i(dw_ready_i), .busy_o(busy_o),
	.done_o(done_o));

// ==== verif/rsrb_host_model.sv ====
`timescale 1ns/1ps
module rsrb_host_model (
	// Clock and bench control
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic [31:0] salt_i,
	// Entry lookup and word sink
	input wire logic [15:0] idx_i,
	output logic [15:0] id_o,
	output logic dyn_o,
	output logic flag_o,
	output logic [127:0] host_o,
	output logic [63:0] key_o,
	output logic rdy_o
);
	logic [31:0] mix;
	logic rdy_q = 1'b1;
	assign mix = salt_i ^ {16'h0, idx_i};
	assign id_o = mix[15:0];
	assign dyn_o = idx_i == 16'h2;
	assign flag_o = idx_i[0];
	assign host_o = {salt_i, ~salt_i, mix, ~mix};
	assign key_o = {~mix, mix + 32'h1};
	// A stalling host drops ready at random just after a rising edge.
	always @(posedge clk_i)
		rdy_q <= !stall_i || ($urandom_range(1) != 0);
	assign rdy_o = rdy_q;
endmodule // rsrb_host_model

// ==== verif/tb_rsrb_builder.sv ====
`timescale 1ns/1ps
module tb_rsrb_builder;
	logic clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, ext = 1'b0;
	logic pers = 1'b0, stall = 1'b0, dyn, flag, rdy, valid, last, done;
	logic [31:0] transfer_dword_count = 32'h0, salt = 32'h0, data;
	logic [15:0] n = 16'h0, idx, cid;
	logic [127:0] hid;
	logic [63:0] key;
	logic busy;
	int mismatches = 0, samples_checked = 0;
	always #25 clk_i = ~clk_i;
	rsrb_builder i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
		.extended_layout_select_i(ext), .transfer_dword_count_i(transfer_dword_count),
		.power_loss_persist_state_i(pers),
		.registered_controller_count_i(n), .entry_idx_o(idx),
		.controller_identifier_i(cid), .dynamic_unassoc_i(dyn),
		.controller_reservation_flag_i(flag), .host_identifier_i(hid),
		.reservation_key_i(key), .dw_valid_o(valid), .dw_data_o(data),
		.dw_last_o(last), .dw_ready_i(rdy), .busy_o(busy), .done_o(done));
	rsrb_host_model i_host (.clk_i(clk_i), .stall_i(stall), .salt_i(salt),
		.idx_i(idx), .id_o(cid), .dyn_o(dyn), .flag_o(flag), .host_o(hid),
		.key_o(key), .rdy_o(rdy));
	function automatic logic [31:0] exp_word(int k);
		int h, e, j;
		logic [31:0] m;
		logic [15:0] id;
		logic [127:0] hv;
		logic [63:0] kv;
		h = ext ? 16 : 6;
		if (k == 1)
			return {8'h0, n, 8'h0};
		if (k == 2)
			return {23'h0, pers, 8'h0};
		if (k < h)
			return 32'h0;
		e = (k - h) / h;
		j = (k - h) % h;
		m = salt ^ e;
		id = (e == 2) ? 16'hFFFF : m[15:0];
		hv = {salt, ~salt, m, ~m};
		kv = {~m, m + 32'h1};
		if (j == 0)
			return {15'h0, e[0], id};
		if (j == 1)
			return 32'h0;
		if (j < 4 && ext)
			return kv[32*(j-2) +: 32];
		if (j < 4)
			return hv[32*(j-2) +: 32];
		if (j < 8 && ext)
			return hv[32*(j-4) +: 32];
		if (j < 6)
			return kv[32*(j-4) +: 32];
		return 32'h0;
	endfunction
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run_report();
		int total, k, t;
		bit hung;
		total = (ext ? 16 : 6) * (n + 1);
		if (transfer_dword_count + 1 < total)
			total = transfer_dword_count + 1;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		k = 0;
		@(negedge clk_i);
		check(busy, 1'b1);
		for (t = 0; t < 3000 && done !== 1'b1; t++)
		begin
			@(negedge clk_i);
			if (valid === 1'b1 && rdy === 1'b1)
			begin
				check(data, exp_word(k));
				check(last, k == total - 1);
				k++;
			end
		end
		hung = (done !== 1'b1);
		check(k, total);
		check(busy, 1'b0);
		@(posedge clk_i);
		if (hung)
		begin
			mismatches++;
			$display("[FAIL] %0t hang got %h exp %h", $time, 0, 1);
			summarize();
		end
	endtask
	initial
	begin
		salt <= $urandom(32'hE1F3);
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			ext <= i[0];
			pers <= i[1];
			stall <= i[2];
			n <= 16'($urandom_range(3));
			transfer_dword_count <= i[3] ? 32'hFFFF_0000 : $urandom_range(70);
			salt <= $urandom();
			@(posedge clk_i);
			run_report();
		end
		summarize();
	end
endmodule // tb_rsrb_builder
